// ### hw/lcdsc_top.sv
// Segment LCD controller: registers, segment storage, pin functions and drive levels
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "lcdsc_consts.svh"

module lcdsc_top #(
    parameter int NUM_PINS     = `LCDSC_NUM_PINS,
    parameter int STEP_DIV     = `LCDSC_STEP_DIV,
    parameter int BLINK_FRAMES = `LCDSC_BLINK_FRAMES
) (
    // Clock and reset
    input  wire logic                  CLK_I,
    input  wire logic                  RST_N_I,
    // Register port
    input  wire logic [7:0]            ADDR_I,
    input  wire logic [31:0]           WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic [31:0]                RDATA_O,
    // Core port logic and peripheral per pin
    input  wire logic [NUM_PINS-1:0]   GPIO_O_I,
    input  wire logic [NUM_PINS-1:0]   GPIO_OE_I,
    input  wire logic [NUM_PINS-1:0]   PERIPH_EN_I,
    input  wire logic [NUM_PINS-1:0]   PERIPH_O_I,
    input  wire logic [NUM_PINS-1:0]   PERIPH_OE_I,
    output logic [NUM_PINS-1:0]        PIN_IN_O,
    // Pads
    input  wire logic [NUM_PINS-1:0]   PIN_I,
    output logic [NUM_PINS-1:0]        PIN_O,
    output logic [NUM_PINS-1:0]        PIN_OE_O,
    output logic [NUM_PINS-1:0]        LCD_EN_O,
    output logic [2*NUM_PINS-1:0]      LCD_LEVEL_O
);

    localparam int NUM_WORDS = `LCDSC_NUM_WORDS;

    // Software registers
    logic [31:0]               map_high_q;       // segment_map_high
    logic [31:0]               map_low_q;        // segment_map_low
    logic [3:0]                segment_index_q;  // segment_index_reg
    logic [31:0]               seg_mem_q [NUM_WORDS]; // segment storage
    logic [2:0]                mux_q;            // multiplex_select
    logic [1:0]                rate_q;           // frame_rate_select
    logic                      force_on_q;       // force_all_on
    logic                      force_off_q;      // force_all_off
    logic                      blink_a_q;        // blink_segment_a enable
    logic                      blink_b_q;        // blink_segment_b enable
    logic [7:0]                com_en_q;         // Pins 0-7 act as commons
    logic                      clear_q;          // display_clear pulse
    logic [31:0]               rdata_q;

    // Pin input synchroniser
    logic [NUM_PINS-1:0]       pin_meta_q;
    logic [NUM_PINS-1:0]       pin_sync_q;

    // Derived views
    logic [63:0]               map_all;          // Map bit of every pin
    logic [31:0]               view_word [NUM_WORDS]; // Words as read back
    logic                      index_ok;         // Index selects a real word
    logic [31:0]               rd_mux;

    // Frame timing
    logic [2:0]                slot;
    logic                      pol;
    logic                      blink_ph;
    logic                      third;
    logic [3:0]                nstates;

    // Output registers
    logic [NUM_PINS-1:0]       pin_o_q;
    logic [NUM_PINS-1:0]       pin_oe_q;
    logic [NUM_PINS-1:0]       lcd_en_q;
    logic [2*NUM_PINS-1:0]     level_q;

    assign map_all  = {map_high_q, map_low_q};
    assign index_ok = (segment_index_q <= `LCDSC_LAST_INDEX);

    // Two-flop synchroniser on the pad inputs
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= PIN_I;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Clear request: lives one cycle, then drops by itself
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || clear_q) begin
            clear_q <= 1'b0;
        end else begin
            clear_q <= WR_I && (ADDR_I == `LCDSC_OFS_MODE) && WDATA_I[`LCDSC_MODE_CLEAR_BIT];
        end
    end

    // Map registers; clear returns every pin to its alternate function
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || clear_q) begin
            map_high_q <= `LCDSC_RST_WORD;
            map_low_q  <= `LCDSC_RST_WORD;
        end else if (WR_I && ADDR_I == `LCDSC_OFS_MAP_HIGH) begin
            map_high_q <= WDATA_I;
        end else if (WR_I && ADDR_I == `LCDSC_OFS_MAP_LOW) begin
            map_low_q  <= WDATA_I;
        end
    end

    // Index register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || clear_q) begin
            segment_index_q <= `LCDSC_RST_INDEX;
        end else if (WR_I && ADDR_I == `LCDSC_OFS_INDEX) begin
            segment_index_q <= WDATA_I[3:0];
        end
    end

    // Display mode register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || clear_q) begin
            mux_q       <= `LCDSC_RST_MUX;
            rate_q      <= `LCDSC_RST_RATE;
            force_on_q  <= 1'b0;
            force_off_q <= 1'b0;
            blink_a_q   <= 1'b0;
            blink_b_q   <= 1'b0;
            com_en_q    <= 8'h00;
        end else if (WR_I && ADDR_I == `LCDSC_OFS_MODE) begin
            mux_q       <= WDATA_I[`LCDSC_MODE_MUX_LSB +: 3];
            rate_q      <= WDATA_I[`LCDSC_MODE_RATE_LSB +: 2];
            force_on_q  <= WDATA_I[`LCDSC_MODE_ON_BIT];
            force_off_q <= WDATA_I[`LCDSC_MODE_OFF_BIT];
            blink_a_q   <= WDATA_I[`LCDSC_MODE_BLINKA_BIT];
            blink_b_q   <= WDATA_I[`LCDSC_MODE_BLINKB_BIT];
            com_en_q    <= WDATA_I[`LCDSC_MODE_COM_LSB +: 8];
        end
    end

    // Segment storage: one word per four pins, written through the window
    genvar gw;
    generate
        for (gw = 0; gw < NUM_WORDS; gw++) begin : g_word
            always_ff @(posedge CLK_I) begin
                if (!RST_N_I || clear_q) begin
                    seg_mem_q[gw] <= `LCDSC_RST_WORD;
                end else if (WR_I && ADDR_I == `LCDSC_OFS_WINDOW && index_ok
                             && segment_index_q == 4'(gw)) begin
                    seg_mem_q[gw] <= WDATA_I;
                end
            end
        end
    endgenerate

    // Frame timing generator
    lcdsc_frame_gen #(
        .STEP_DIV     (STEP_DIV),
        .BLINK_FRAMES (BLINK_FRAMES)
    ) u_frame (
        .clk_i      (CLK_I),
        .rst_n_i    (RST_N_I),
        .clear_i    (clear_q),
        .rate_sel_i (rate_q),
        .mux_i      (lcdsc_pkg::lcdsc_mux_type'(mux_q)),
        .slot_o     (slot),
        .pol_o      (pol),
        .blink_o    (blink_ph),
        .third_o    (third),
        .nstates_o  (nstates)
    );

    // Per pin: storage byte, pin function and drive level
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
            localparam int W = gp / 4;
            localparam int B = (3 - (gp % 4)) * 8;
            logic [7:0]                  seg_byte;  // segment_byte of this pin
            logic                        mapped;
            logic                        is_com;
            logic                        seg_on;
            logic                        hit;
            logic                        blinks;
            lcdsc_pkg::lcdsc_level_type  lvl;

            assign seg_byte = seg_mem_q[W][B +: 8];
            assign mapped   = map_all[gp];
            // Pins 0-7 may act as commons 0-7
            if (gp < `LCDSC_NUM_COMS) begin : g_com
                assign is_com = com_en_q[gp];
            end else begin : g_seg
                assign is_com = 1'b0;
            end
            if (gp == `LCDSC_BLINK_PIN_A) begin : g_blink_a
                assign blinks = blink_a_q && blink_ph;
            end else if (gp == `LCDSC_BLINK_PIN_B) begin : g_blink_b
                assign blinks = blink_b_q && blink_ph;
            end else begin : g_noblink
                assign blinks = 1'b0;
            end

            // Segment state in the current slot; off wins over on
            assign seg_on = force_off_q ? 1'b0 :
                            force_on_q  ? 1'b1 :
                            (seg_byte[slot] && !blinks);
            // Common selected only in its slot and only if used by the mode
            assign hit = is_com ? ((slot == 3'(gp)) && (4'(gp) < nstates)) : seg_on;
            assign lvl = lcdsc_pkg::lcdsc_level_f(is_com, hit, pol, third);

            // Read view: input value shows in bit 0 of an unmapped input pin
            assign view_word[W][B +: 8] = (!mapped && !seg_byte[2] && !seg_byte[1]) ?
                                          {seg_byte[7:1], pin_sync_q[gp]} : seg_byte;

            // Registered pin outputs
            always_ff @(posedge CLK_I) begin
                if (!RST_N_I) begin
                    pin_o_q[gp]         <= 1'b0;
                    pin_oe_q[gp]        <= 1'b0;
                    lcd_en_q[gp]        <= 1'b0;
                    level_q[2*gp +: 2]  <= 2'h0;
                end else if (mapped) begin
                    // LCD owns the pin; alternate function fully off
                    pin_o_q[gp]         <= 1'b0;
                    pin_oe_q[gp]        <= 1'b0;
                    lcd_en_q[gp]        <= 1'b1;
                    level_q[2*gp +: 2]  <= lvl;
                end else if (seg_byte[2]) begin
                    // Port logic: peripheral first, else GPIO
                    pin_o_q[gp]         <= PERIPH_EN_I[gp] ? PERIPH_O_I[gp] : GPIO_O_I[gp];
                    pin_oe_q[gp]        <= PERIPH_EN_I[gp] ? PERIPH_OE_I[gp] : GPIO_OE_I[gp];
                    lcd_en_q[gp]        <= 1'b0;
                    level_q[2*gp +: 2]  <= 2'h0;
                end else begin
                    // Direct I/O from the segment byte
                    pin_o_q[gp]         <= seg_byte[0];
                    pin_oe_q[gp]        <= seg_byte[1];
                    lcd_en_q[gp]        <= 1'b0;
                    level_q[2*gp +: 2]  <= 2'h0;
                end
            end
        end
    endgenerate

    // Read multiplexer
    always_comb begin
        rd_mux = 32'h0;
        unique case (ADDR_I)
            `LCDSC_OFS_MAP_HIGH: rd_mux = map_high_q;
            `LCDSC_OFS_MAP_LOW:  rd_mux = map_low_q;
            `LCDSC_OFS_INDEX:    rd_mux = {28'h0, segment_index_q};
            `LCDSC_OFS_WINDOW:   rd_mux = index_ok ? view_word[segment_index_q] : 32'h0;
            `LCDSC_OFS_MODE: begin
                rd_mux[`LCDSC_MODE_MUX_LSB +: 3]  = mux_q;
                rd_mux[`LCDSC_MODE_RATE_LSB +: 2] = rate_q;
                rd_mux[`LCDSC_MODE_ON_BIT]        = force_on_q;
                rd_mux[`LCDSC_MODE_OFF_BIT]       = force_off_q;
                rd_mux[`LCDSC_MODE_BLINKA_BIT]    = blink_a_q;
                rd_mux[`LCDSC_MODE_BLINKB_BIT]    = blink_b_q;
                rd_mux[`LCDSC_MODE_COM_LSB +: 8]  = com_en_q;
            end
            `LCDSC_OFS_STATUS:   rd_mux = {26'h0, blink_ph, pol, nstates == 4'h1, slot};
            default:             rd_mux = 32'h0;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= RD_I ? rd_mux : 32'h0;
        end
    end

    // Synchronised pad inputs to the core
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            PIN_IN_O <= '0;
        end else begin
            PIN_IN_O <= pin_sync_q;
        end
    end

    assign RDATA_O     = rdata_q;
    assign PIN_O       = pin_o_q;
    assign PIN_OE_O    = pin_oe_q;
    assign LCD_EN_O    = lcd_en_q;
    assign LCD_LEVEL_O = level_q;

endmodule : lcdsc_top

// ### common/lcdsc_consts.svh
// Register offsets, field positions, reset values and timing counts of the segment LCD controller
`ifndef LCDSC_CONSTS_SVH
`define LCDSC_CONSTS_SVH

// Register byte offsets
`define LCDSC_OFS_MAP_HIGH     8'h00
`define LCDSC_OFS_MAP_LOW      8'h04
`define LCDSC_OFS_INDEX        8'h08
`define LCDSC_OFS_WINDOW       8'h0C
`define LCDSC_OFS_MODE         8'h10
`define LCDSC_OFS_STATUS       8'h14

// Display mode register fields
`define LCDSC_MODE_MUX_LSB     0
`define LCDSC_MODE_RATE_LSB    4
`define LCDSC_MODE_ON_BIT      8
`define LCDSC_MODE_OFF_BIT     9
`define LCDSC_MODE_CLEAR_BIT   10
`define LCDSC_MODE_BLINKA_BIT  12
`define LCDSC_MODE_BLINKB_BIT  13
`define LCDSC_MODE_COM_LSB     16

// Reset values
`define LCDSC_RST_WORD         32'h0000_0000
`define LCDSC_RST_INDEX        4'h0
`define LCDSC_RST_RATE         2'h0
`define LCDSC_RST_MUX          3'h0

// Storage geometry
`define LCDSC_NUM_PINS         44
`define LCDSC_NUM_WORDS        11
`define LCDSC_LAST_INDEX       4'hA
`define LCDSC_BLINK_PIN_A      22
`define LCDSC_BLINK_PIN_B      23
`define LCDSC_NUM_COMS         8

// Timing
`define LCDSC_CLK_HZ           200000000
`define LCDSC_BASE_FRAME_HZ    64
`define LCDSC_STEPS_PER_FRAME  16
`define LCDSC_STEP_DIV         (`LCDSC_CLK_HZ / (`LCDSC_BASE_FRAME_HZ * `LCDSC_STEPS_PER_FRAME))
`define LCDSC_BLINK_FRAMES     32

`endif

// ### common/lcdsc_pkg.sv
// Types and drive-level helper of the segment LCD controller
package lcdsc_pkg;

    // Multiplex and bias selections
    typedef enum logic [2:0] {
        MUX_4_THIRD  = 3'h0,
        MUX_3_THIRD  = 3'h1,
        MUX_2_HALF   = 3'h2,
        MUX_3_HALF   = 3'h3,
        MUX_STATIC   = 3'h4,
        MUX_5_THIRD  = 3'h5,
        MUX_6_THIRD  = 3'h6,
        MUX_8_THIRD  = 3'h7
    } lcdsc_mux_type;

    // Rail code: 0 ground, 3 full, 1 and 2 intermediate rails
    typedef logic [1:0] lcdsc_level_type;

    // Drive level of one pin for one slot and polarity
    function automatic lcdsc_level_type lcdsc_level_f(input logic is_com, input logic hit,
                                                      input logic pol, input logic third);
        lcdsc_level_type sel_lvl;
        sel_lvl = pol ? 2'h0 : 2'h3;
        if (is_com) begin
            return hit ? sel_lvl : ((pol && third) ? 2'h2 : 2'h1);
        end
        if (hit) begin
            return ~sel_lvl;
        end
        return third ? (pol ? 2'h1 : 2'h2) : sel_lvl;
    endfunction : lcdsc_level_f

endpackage : lcdsc_pkg

// ### hw/lcdsc_frame_gen.sv
// Frame timing: step divider, common slot walk, polarity and blink phase
`timescale 1ns/100ps
`include "lcdsc_consts.svh"

module lcdsc_frame_gen #(
    parameter int STEP_DIV     = `LCDSC_STEP_DIV,
    parameter int BLINK_FRAMES = `LCDSC_BLINK_FRAMES
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clear_i,
    // Configuration
    input  wire logic [1:0]             rate_sel_i,
    input  wire lcdsc_pkg::lcdsc_mux_type mux_i,
    // Timing state
    output logic [2:0]                  slot_o,
    output logic                        pol_o,
    output logic                        blink_o,
    output logic                        third_o,
    output logic [3:0]                  nstates_o
);

    logic [23:0] step_cnt_q;     // Cycles within one step
    logic [23:0] step_last;      // Terminal count for the chosen rate
    logic        step_hit;       // One step elapsed
    logic        frame_end;      // Last slot of the frame ends
    logic [5:0]  blink_cnt_q;    // Frames within one blink half period
    logic [2:0]  slot_q;
    logic        pol_q;
    logic        blink_q;

    // Each rate code doubles the frame clock
    assign step_last = (24'(STEP_DIV) >> rate_sel_i) - 24'h1;
    assign step_hit  = (step_cnt_q >= step_last);
    assign frame_end = step_hit && ({1'b0, slot_q} >= nstates_o - 4'h1);

    // Number of states and bias for each multiplex code
    always_comb begin
        unique case (mux_i)
            lcdsc_pkg::MUX_4_THIRD: begin nstates_o = 4'h4; third_o = 1'b1; end
            lcdsc_pkg::MUX_3_THIRD: begin nstates_o = 4'h3; third_o = 1'b1; end
            lcdsc_pkg::MUX_2_HALF:  begin nstates_o = 4'h2; third_o = 1'b0; end
            lcdsc_pkg::MUX_3_HALF:  begin nstates_o = 4'h3; third_o = 1'b0; end
            lcdsc_pkg::MUX_STATIC:  begin nstates_o = 4'h1; third_o = 1'b0; end
            lcdsc_pkg::MUX_5_THIRD: begin nstates_o = 4'h5; third_o = 1'b1; end
            lcdsc_pkg::MUX_6_THIRD: begin nstates_o = 4'h6; third_o = 1'b1; end
            lcdsc_pkg::MUX_8_THIRD: begin nstates_o = 4'h8; third_o = 1'b1; end
        endcase
    end

    // Step divider
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_i || step_hit) begin
            step_cnt_q <= 24'h0;
        end else begin
            step_cnt_q <= step_cnt_q + 24'h1;
        end
    end

    // Slot walk and polarity inversion once per frame
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_i) begin
            slot_q <= 3'h0;
            pol_q  <= 1'b0;
        end else if (frame_end) begin
            slot_q <= 3'h0;
            pol_q  <= ~pol_q;
        end else if (step_hit) begin
            slot_q <= slot_q + 3'h1;
        end
    end

    // Blink phase toggles every BLINK_FRAMES frames
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clear_i) begin
            blink_cnt_q <= 6'h0;
            blink_q     <= 1'b0;
        end else if (frame_end) begin
            if (blink_cnt_q >= 6'(BLINK_FRAMES - 1)) begin
                blink_cnt_q <= 6'h0;
                blink_q     <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 6'h1;
            end
        end
    end

    assign slot_o  = slot_q;
    assign pol_o   = pol_q;
    assign blink_o = blink_q;

endmodule : lcdsc_frame_gen

// ### bench/lcdsc_top_properties.sv
// Port-level assertions of the segment LCD controller, bound to its top module
`timescale 1ns/100ps

module lcdsc_top_properties #(
    parameter int NUM_PINS = 44
) (
    // Clock and reset
    input  wire logic                  CLK_I,
    input  wire logic                  RST_N_I,
    // Register port
    input  wire logic [7:0]            ADDR_I,
    input  wire logic [31:0]           WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    input  wire logic [31:0]           RDATA_O,
    // Pad side
    input  wire logic [NUM_PINS-1:0]   PIN_OE_O,
    input  wire logic [NUM_PINS-1:0]   LCD_EN_O,
    input  wire logic [2*NUM_PINS-1:0] LCD_LEVEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic [2*NUM_PINS-1:0] en_pair;  // Map state widened to both level bits

    // Spread each pin's map state over its level pair
    always_comb begin
        for (int p = 0; p < NUM_PINS; p++) begin
            en_pair[2*p]   = LCD_EN_O[p];
            en_pair[2*p+1] = LCD_EN_O[p];
        end
    end

    // Clear-bit write on the mode register
    sequence s_clear_wr;
        WR_I && ADDR_I == 8'h10 && WDATA_I[10];
    endsequence

    // Map write not swallowed by a clear cycle and not followed by a mode write
    sequence s_map_wr(logic [7:0] a);
        !$past(WR_I && ADDR_I == 8'h10 && WDATA_I[10]) && WR_I && ADDR_I == a
        ##1 !(WR_I && ADDR_I == 8'h10);
    endsequence

    a_map_low_pins: assert property (s_map_wr(8'h04) |-> ##1
        LCD_EN_O[31:0] == $past(WDATA_I, 2)) else $error("low map not on pins");
    a_map_high_pins: assert property (s_map_wr(8'h00) |-> ##1
        LCD_EN_O[NUM_PINS-1:32] == $past(WDATA_I[NUM_PINS-33:0], 2))
        else $error("high map not on pins");
    a_clear_wipes_pins: assert property (s_clear_wr |-> ##3
        (LCD_EN_O == '0 && PIN_OE_O == '0)) else $error("clear left pins set");
    a_clear_reads_zero: assert property (RD_I && ADDR_I == 8'h10 |=> !RDATA_O[10])
        else $error("clear bit read as one");
    a_rdata_idle_zero: assert property (!RD_I |=> RDATA_O == '0)
        else $error("read data outside read slot");
    a_unmapped_read: assert property (RD_I && ADDR_I > 8'h14 |=> RDATA_O == '0)
        else $error("unmapped address read nonzero");
    a_lcd_no_drive: assert property ((LCD_EN_O & PIN_OE_O) == '0)
        else $error("mapped pin driven digitally");
    a_unmapped_level: assert property ((LCD_LEVEL_O & ~en_pair) == '0)
        else $error("unmapped pin has drive level");
endmodule : lcdsc_top_properties

bind lcdsc_top lcdsc_top_properties #(.NUM_PINS(NUM_PINS)) u_props (
    .CLK_I       (CLK_I),
    .RST_N_I     (RST_N_I),
    .ADDR_I      (ADDR_I),
    .WDATA_I     (WDATA_I),
    .WR_I        (WR_I),
    .RD_I        (RD_I),
    .RDATA_O     (RDATA_O),
    .PIN_OE_O    (PIN_OE_O),
    .LCD_EN_O    (LCD_EN_O),
    .LCD_LEVEL_O (LCD_LEVEL_O)
);

// ### bench/lcdsc_glass.sv
// Passive glass model: rail steps across one segment and one common electrode
`timescale 1ns/100ps

module lcdsc_glass #(
    parameter int NUM_PINS = 44
) (
    // Drive levels from the controller
    input  wire logic [2*NUM_PINS-1:0] level_i,
    // Electrodes forming the watched pixel
    input  wire logic [5:0]            com_pin_i,
    input  wire logic [5:0]            seg_pin_i,
    // Swing across the pixel; dark when the full swing is seen
    output logic [1:0]                 diff_o,
    output logic                       dark_o
);
    logic [1:0] com_lvl;  // Backplane rail
    logic [1:0] seg_lvl;  // Front electrode rail

    // Pixel only sees the difference of its two electrodes
    always_comb begin
        com_lvl = level_i[2*com_pin_i +: 2];
        seg_lvl = level_i[2*seg_pin_i +: 2];
        diff_o  = (com_lvl > seg_lvl) ? com_lvl - seg_lvl : seg_lvl - com_lvl;
        dark_o  = (diff_o == 2'h3);
    end
endmodule : lcdsc_glass

// ### bench/lcdsc_top_test.sv
// Self-checking bench of the segment LCD controller
`timescale 1ns/100ps

module lcdsc_top_test;
    localparam int NP   = 44;
    localparam int STEP = 8;  // Short step divider for simulation

    logic            clk, rst_n, wr, rd, dark;
    logic [7:0]      addr;
    logic [31:0]     wdata, rdata, d, e;
    logic [NP-1:0]   gpio_o, gpio_oe, per_en, per_o, per_oe, pin_in, pad_in, pin_o, pin_oe;
    logic [NP-1:0]   lcd_en;
    logic [2*NP-1:0] lvl;
    logic [1:0]      diff, mx;
    logic [5:0]      seg_pin;
    int              checks, fail_count, cyc, n;

    lcdsc_top #(.STEP_DIV(STEP), .BLINK_FRAMES(2)) DUT (
        .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .GPIO_O_I(gpio_o), .GPIO_OE_I(gpio_oe),
        .PERIPH_EN_I(per_en), .PERIPH_O_I(per_o), .PERIPH_OE_I(per_oe),
        .PIN_IN_O(pin_in), .PIN_I(pad_in), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
        .LCD_EN_O(lcd_en), .LCD_LEVEL_O(lvl));

    // Glass pixel between common pin 0 and a chosen segment pin
    lcdsc_glass #(.NUM_PINS(NP)) u_glass (.level_i(lvl), .com_pin_i(6'h0),
        .seg_pin_i(seg_pin), .diff_o(diff), .dark_o(dark));

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic seg_wr(input logic [31:0] i, input logic [31:0] v);
        wr_reg(8'h08, i);
        wr_reg(8'h0C, v);
    endtask : seg_wr

    task automatic seg_rd(input logic [31:0] i, output logic [31:0] v);
        wr_reg(8'h08, i);
        rd_reg(8'h0C, v);
    endtask : seg_rd

    // Largest swing and dark cycles over a window
    task automatic watch(input int w, output logic [1:0] m, output int on);
        m = 2'h0;
        on = 0;
        repeat (40) @(posedge clk);
        repeat (w) begin
            @(posedge clk);
            #1;
            if (diff > m) m = diff;
            if (dark === 1'b1) on++;
        end
    endtask : watch

    // Cycles between two changes of the common pin's level
    task automatic step_len(output int k);
        logic [1:0] last;
        @(posedge clk);
        #1 last = lvl[1:0];
        while (lvl[1:0] === last) @(posedge clk) #1;
        k = 0;
        #1 last = lvl[1:0];
        while (lvl[1:0] === last) begin
            @(posedge clk);
            #1 k++;
        end
    endtask : step_len

    task automatic print_verdict;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        {rst_n, wr, rd, addr, wdata, cyc, checks, fail_count} = '0;
        {gpio_o, gpio_oe, per_en, per_o, per_oe, pad_in} = '0;
        seg_pin = 6'h9;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state and an unmapped address
        rd_reg(8'h04, d);
        chk(d, 32'h0);
        rd_reg(8'h10, d);
        chk(d & 32'h30, 32'h0);
        wr_reg(8'h18, 32'hFFFFFFFF);
        rd_reg(8'h18, d);
        chk(d, 32'h0);
        // Every word through the window, then indexes past the last word
        for (int i = 0; i < 11; i++) seg_wr(i, 32'h0C0D0E0F + i * 32'h10101010);
        for (int i = 0; i < 11; i++) begin
            seg_rd(i, d);
            chk(d, 32'h0C0D0E0F + i * 32'h10101010);
        end
        for (int i = 11; i < 16; i += 4) begin
            seg_wr(i, 32'hFFFFFFFF);
            seg_rd(i, d);
            chk(d, 32'h0);
        end
        seg_rd(10, d);
        chk(d, 32'hACADAEAF);
        $display("test window done");
        // Digital pin functions of word 0
        @(posedge clk);
        gpio_o <= 44'h1;
        per_en <= 44'h1;
        per_oe <= 44'h1;
        pad_in <= 44'h8;
        seg_wr(0, 32'h04030200);
        repeat (4) @(posedge clk);
        #1 chk(32'(pin_oe[3:0]), 32'h7);
        chk(32'(pin_o[3:0]), 32'h2);
        @(posedge clk);
        per_en <= '0;
        repeat (4) @(posedge clk);
        #1 chk(32'(pin_o[0]), 32'h1);
        chk(32'(pin_in[3]), 32'h1);
        seg_rd(0, d);
        chk(d, 32'h04030201);
        // Mapping takes pins away from digital use
        wr_reg(8'h04, 32'h202);
        wr_reg(8'h00, 32'h800);
        repeat (4) @(posedge clk);
        #1 chk(32'(lcd_en[3:0]), 32'h2);
        chk(32'(pin_oe[1]), 32'h0);
        chk(32'(lcd_en[43]), 32'h1);
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h04, 32'h201);
        $display("test pins done");
        // Every mux code with segment byte off, slot 0 on, slot 1 on
        for (int v = 0; v < 3; v++) begin
            seg_wr(2, 32'(v) << 16);
            for (int m = 0; m < 8; m++) begin
                wr_reg(8'h10, 32'h10000 | m);
                watch(200, mx, n);
                e = v == 1 ? 32'h3 : m == 4 ? 32'h0 : (m == 2 || m == 3) ? 32'h2 : 32'h1;
                chk(32'(mx), e);
            end
        end
        // Force on, force off, both
        for (int f = 1; f < 4; f++) begin
            wr_reg(8'h10, 32'h10000 | f << 8);
            watch(200, mx, n);
            chk(32'(mx), f == 1 ? 32'h3 : 32'h1);
        end
        seg_rd(2, d);
        chk(d, 32'h20000);
        $display("test drive done");
        // Blinking on each of the two blink pins
        seg_wr(5, 32'h101);
        wr_reg(8'h04, 32'hC00001);
        for (int b = 0; b < 2; b++) begin
            seg_pin = 6'(22 + b);
            wr_reg(8'h10, 32'h10002);
            watch(400, mx, n);
            chk(32'(n), 32'hC8);
            wr_reg(8'h10, 32'h10002 | 32'h1000 << b);
            watch(400, mx, n);
            chk(32'(n > 0 && n < 200), 32'h1);
        end
        // Step length for each frame rate code
        for (int r = 0; r < 4; r++) begin
            wr_reg(8'h10, 32'h10002 | r << 4);
            step_len(n);
            step_len(n);
            chk(32'(n), 32'(STEP >> r));
        end
        $display("test timing done");
        // Clear wipes maps, mode and storage
        wr_reg(8'h10, 32'h400);
        repeat (4) @(posedge clk);
        #1 chk(32'(|lcd_en), 32'h0);
        rd_reg(8'h10, d);
        chk(d, 32'h0);
        seg_rd(0, d);
        chk(d, 32'h1);
        $display("test clear done");
        print_verdict();
    end
endmodule : lcdsc_top_test
